// file: rtl/sramc_ctrl.sv
// Controller that drives an asynchronous 256K x 16 static memory over its pins
`timescale 1ns/1ns
module sramc_ctrl
  import sramc_pkg::*;
(
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire sramc_req_t req, // Request contents
  input wire logic req_valid, // Request offered
  output logic req_ready_reg, // Controller idle, request taken when valid
  output logic [DATA_W-1:0] rdata_reg, // Read data
  output logic rdata_valid_reg, // One-cycle pulse with read data
  output logic wdone_reg, // One-cycle pulse at write end
  output sramc_pins_t pins_reg, // Memory control and address pins
  output logic [DATA_W-1:0] data_bus_o_reg, // Data to memory
  output logic data_bus_oe_reg, // High while controller drives data bus
  input wire logic [DATA_W-1:0] data_bus_i // Data bus as seen at the pins
);
  typedef enum logic [2:0] {S_IDLE, S_RD, S_TA, S_WSET, S_WP, S_WEND} sramc_state_t;

  sramc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  sramc_req_t cur_reg;
  logic [DATA_W-1:0] din_s1_reg, din_s2_reg;
  logic last_rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire take = req_ready_reg & req_valid;
  wire rd_take = take & ~req.write;
  wire wr_take = take & req.write;
  wire cnt_done = (cnt_reg == CNT_ONE);
  wire [CNT_W-1:0] cnt_dec = (cnt_reg == CNT_ZERO) ? CNT_ZERO : CNT_W'(cnt_reg - CNT_ONE);
  wire [1:0] lanes_n = ~req.lane_sel;
  // Both lanes off would make the access a no-op; treat as word access
  wire [1:0] lanes_use_n = (lanes_n == 2'h3) ? 2'h0 : lanes_n;
  wire [1:0] cur_lanes_n = (~cur_reg.lane_sel == 2'h3) ? 2'h0 : ~cur_reg.lane_sel;
  // Write pulse length depends on output enable held low
  wire [CNT_W-1:0] wp_len = cur_reg.keep_oe ? WPOE_CNT : WP_CNT;
  wire [DATA_W-1:0] lane_mask = {{LANE_W{~cur_lanes_n[1]}}, {LANE_W{~cur_lanes_n[0]}}};
  // Read data reaches the second sync stage two edges after the access time,
  // so the strobes stand that much longer than the bare access count
  wire [CNT_W-1:0] rd_len = CNT_W'(RD_CNT + CNT_ONE + CNT_ONE);
  wire rd_end = (state_reg == S_RD) && cnt_done;
  // Pin fields come from the request on the take edge, from the copy after it
  wire [ADDR_W-1:0] acc_addr = take ? req.addr : cur_reg.addr;
  wire [1:0] acc_lanes_n = take ? lanes_use_n : cur_lanes_n;
  wire acc_oe_n = take ? ~req.keep_oe : ~cur_reg.keep_oe;
  // With output enable low the memory lets go of the bus only after write
  // enable falls, so data drive waits one cycle inside the two-cycle pulse
  wire wp_drive = ~cur_reg.keep_oe | (state_reg == S_WP);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_dec;
    // Reads count access plus sync; writes go set-up, pulse, end, after a turnaround if the last access was a read
    case (state_reg)
      S_IDLE: begin
        if (rd_take) begin
          state_next = S_RD;
          cnt_next = rd_len;
        end else if (wr_take && last_rd_reg) begin
          // A write right after a read first lets the memory release the bus
          state_next = S_TA;
          cnt_next = TA_CNT;
        end else if (wr_take) begin
          state_next = S_WSET;
        end
      end
      S_RD: begin
        if (cnt_done) begin
          state_next = S_IDLE;
        end
      end
      S_TA: begin
        if (cnt_done) begin
          state_next = S_WSET;
        end
      end
      S_WSET: begin
        state_next = S_WP;
        cnt_next = wp_len;
      end
      S_WP: begin
        if (cnt_done) begin
          state_next = S_WEND;
        end
      end
      S_WEND: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, request and input synchroniser
  // Request copy is held for the whole access; last_rd_reg picks the turnaround
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      cnt_reg <= CNT_ZERO;
      cur_reg <= '0;
      last_rd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (take) begin
        cur_reg <= req;
        last_rd_reg <= !req.write;
      end
    end
  end

  // Data bus pins are asynchronous to clk_sys
  // Only the second stage feeds logic; the first may still be settling
  // Read data is therefore taken two edges after it is due at the pins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
    end else begin
      din_s1_reg <= data_bus_i;
      din_s2_reg <= din_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  // Address, select and lanes set together at request, or after the turnaround for a write after a read; write enable falls a
  // cycle later; the memory drives the bus in the write only in set-up, and only with output enable held low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pins_reg <= PINS_IDLE;
      data_bus_oe_reg <= 1'b0;
      data_bus_o_reg <= '0;
    end else begin
      case (state_next)
        S_RD: begin
          // Strobes and address stand unchanged for the whole count
          pins_reg.word_addr <= acc_addr;
          pins_reg.chip_sel_n <= 1'b0;
          pins_reg.write_en_n <= 1'b1;
          pins_reg.out_en_n <= 1'b0;
          pins_reg.upper_lane_en_n <= acc_lanes_n[1];
          pins_reg.lower_lane_en_n <= acc_lanes_n[0];
          data_bus_oe_reg <= 1'b0;
        end
        S_WSET: begin
          // Select and lanes fall before write enable; output enable per request
          pins_reg.word_addr <= acc_addr;
          pins_reg.chip_sel_n <= 1'b0;
          pins_reg.write_en_n <= 1'b1;
          pins_reg.out_en_n <= acc_oe_n;
          pins_reg.upper_lane_en_n <= acc_lanes_n[1];
          pins_reg.lower_lane_en_n <= acc_lanes_n[0];
          data_bus_oe_reg <= 1'b0;
        end
        S_WP: begin
          // Data launched inside the pulse and held until the pins go idle
          pins_reg.write_en_n <= 1'b0;
          data_bus_oe_reg <= wp_drive;
          data_bus_o_reg <= cur_reg.wdata;
        end
        S_WEND: begin
          // Write and output enables rise together, so the memory does not
          // turn its drivers back on while our data is still held
          pins_reg.write_en_n <= 1'b1; // data held past write end
          pins_reg.out_en_n <= 1'b1;
        end
        S_TA: begin
          // All strobes high while the memory lets go of the bus
          pins_reg <= PINS_IDLE;
          data_bus_oe_reg <= 1'b0;
        end
        default: begin
          pins_reg <= PINS_IDLE;
          data_bus_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User side answers; unused lanes read as zero
  // Ready rises as the machine heads back to idle and drops on the take edge
  // Pulses stand for one cycle; read data holds until the next read ends
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      req_ready_reg <= 1'b0;
      rdata_reg <= '0;
      rdata_valid_reg <= 1'b0;
      wdone_reg <= 1'b0;
    end else begin
      req_ready_reg <= (state_next == S_IDLE) && !take;
      rdata_valid_reg <= rd_end;
      if (rd_end) begin
        rdata_reg <= din_s2_reg & lane_mask;
      end
      wdone_reg <= (state_reg == S_WEND);
    end
  end
endmodule

// file: rtl/sramc_pkg.sv
// Package for the static memory controller: widths, timing figures and carriers
package sramc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // Clock period in picoseconds (125 MHz)
  localparam int CLK_PS = 8000;
  // Timing figures in picoseconds, slowest speed grade
  localparam int T_RC_PS = 15000; // read cycle and address access
  localparam int T_WP_PS = 10000; // bare write pulse
  localparam int T_WHZ_PS = 7000; // write enable low to outputs off
  localparam int T_DW_PS = 7000; // data_setup_to_write_end
  localparam int T_OHZ_PS = 7000; // output enable high to outputs off
  // Cycle counts, least times rounded up
  localparam int RD_CYC = (T_RC_PS + CLK_PS - 1) / CLK_PS;
  localparam int WP_CYC = (T_WP_PS + CLK_PS - 1) / CLK_PS;
  localparam int WPOE_CYC = (T_WHZ_PS + T_DW_PS + CLK_PS - 1) / CLK_PS;
  localparam int TA_CYC = (T_OHZ_PS + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC);
  localparam logic [CNT_W-1:0] WPOE_CNT = CNT_W'(WPOE_CYC);
  localparam logic [CNT_W-1:0] TA_CNT = CNT_W'(TA_CYC);
  // User request carrier
  typedef struct packed {
    logic write;
    logic keep_oe; // hold output enable low during a write
    logic [1:0] lane_sel; // bit1 upper lane, bit0 lower lane, high = use
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sramc_req_t;
  // Memory pin carrier, control pins active low
  typedef struct packed {
    logic chip_sel_n;
    logic write_en_n;
    logic out_en_n;
    logic upper_lane_en_n;
    logic lower_lane_en_n;
    logic [ADDR_W-1:0] word_addr;
  } sramc_pins_t;
  localparam sramc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
endpackage

// file: sim/sramc_ctrl_monitor.sv
// Checker of the memory pin protocol
`timescale 1ns/1ns
module sramc_ctrl_monitor
  import sramc_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset, active low
  input wire sramc_req_t req, // Request
  input wire logic req_valid, // Offered
  input wire logic req_ready_reg, // Idle
  input wire logic rdata_valid_reg, // Read answer
  input wire logic wdone_reg, // Write answer
  input wire sramc_pins_t pins_reg, // Pins
  input wire logic data_bus_oe_reg // Data drive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_we_sel;
    !pins_reg.write_en_n |-> !pins_reg.chip_sel_n;
  endproperty
  a_we_sel: assert property (p_we_sel) else $error("write without select");
  property p_cs_first;
    $fell(pins_reg.write_en_n) |-> !$past(pins_reg.chip_sel_n);
  endproperty
  a_cs_first: assert property (p_cs_first) else $error("select late");
  property p_wp;
    $fell(pins_reg.write_en_n) |-> !pins_reg.write_en_n [*2];
  endproperty
  a_wp: assert property (p_wp) else $error("write pulse short");
  property p_turn;
    $fell(pins_reg.write_en_n) && !pins_reg.out_en_n |-> !data_bus_oe_reg;
  endproperty
  a_turn: assert property (p_turn) else $error("data driven too early");
  property p_rd_off;
    !pins_reg.chip_sel_n && !pins_reg.out_en_n && pins_reg.write_en_n |-> !data_bus_oe_reg;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("bus contention");
  property p_addr;
    !pins_reg.chip_sel_n && !$past(pins_reg.chip_sel_n) |-> $stable(pins_reg.word_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_rd_done;
    req_valid && req_ready_reg && !req.write |-> ##5 rdata_valid_reg;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read late");
  property p_wr_done;
    req_valid && req_ready_reg && req.write |-> ##[5:6] wdone_reg;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write late");
endmodule
////////////////////////////////////////
bind sramc_ctrl sramc_ctrl_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .req(req),
  .req_valid(req_valid), .req_ready_reg(req_ready_reg), .rdata_valid_reg(rdata_valid_reg),
  .wdone_reg(wdone_reg), .pins_reg(pins_reg), .data_bus_oe_reg(data_bus_oe_reg));

// file: sim/sramc_mem_model.sv
// Behavioural model of the static memory
`timescale 1ns/1ns
module sramc_mem_model
  import sramc_pkg::*;
#(parameter int ACC_NS = 15)
(
  input wire sramc_pins_t pins, // Pins
  input wire logic [DATA_W-1:0] data_bus, // Bus level
  output logic [DATA_W-1:0] mem_q, // Read data
  output logic [1:0] mem_drv // Lane drive
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] old_w;
  logic rd_on;
  // Drive enabled lanes only in a selected read
  assign rd_on = !pins.chip_sel_n && !pins.out_en_n && pins.write_en_n;
  assign mem_drv = {2{rd_on}} & ~{pins.upper_lane_en_n, pins.lower_lane_en_n};
  // Data appears after the access time
  always @(pins.word_addr, rd_on) begin
    mem_q <= #ACC_NS (mem.exists(pins.word_addr) ? mem[pins.word_addr] : 16'hA5A5);
  end
  // Store enabled lanes at the end of the overlap
  always @(posedge pins.write_en_n) begin
    if (!pins.chip_sel_n) begin
      old_w = mem.exists(pins.word_addr) ? mem[pins.word_addr] : 16'h0000;
      mem[pins.word_addr] = {pins.upper_lane_en_n ? old_w[15:8] : data_bus[15:8],
        pins.lower_lane_en_n ? old_w[7:0] : data_bus[7:0]};
    end
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench of the memory controller
`timescale 1ns/1ns
module tb_top
  import sramc_pkg::*;
;
  logic clk_sys = 0, nrst = 0, req_valid = 0, req_ready_reg, rdata_valid_reg, wdone_reg;
  logic data_bus_oe_reg;
  sramc_req_t req = '0;
  sramc_pins_t pins_reg;
  logic [DATA_W-1:0] rdata_reg, data_bus_o_reg, mem_q, float_pat = 16'h5A3C;
  logic [1:0] mem_drv;
  wire [DATA_W-1:0] data_bus;
  int mismatches = 0, check_count = 0, ref_mem [int];
  logic [31:0] seed = 32'h000128B1;
  always #4 clk_sys = ~clk_sys;
  // Released lanes show a changing pattern
  always @(posedge clk_sys) float_pat <= ~float_pat;
  // Bus level from every driver
  assign data_bus[7:0] = mem_drv[0] ? mem_q[7:0] :
    data_bus_oe_reg ? data_bus_o_reg[7:0] : float_pat[7:0];
  assign data_bus[15:8] = mem_drv[1] ? mem_q[15:8] :
    data_bus_oe_reg ? data_bus_o_reg[15:8] : float_pat[15:8];
  sramc_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_valid(req_valid),
    .req_ready_reg(req_ready_reg), .rdata_reg(rdata_reg), .rdata_valid_reg(rdata_valid_reg),
    .wdone_reg(wdone_reg), .pins_reg(pins_reg), .data_bus_o_reg(data_bus_o_reg),
    .data_bus_oe_reg(data_bus_oe_reg), .data_bus_i(data_bus));
  sramc_mem_model #(.ACC_NS(15)) u_mem (.pins(pins_reg), .data_bus(data_bus),
    .mem_q(mem_q), .mem_drv(mem_drv));
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction
  function automatic logic [17:0] addr_of(input logic [1:0] i);
    return i[1] ? {17'h1FFFF, i[0]} : {17'h00000, i[0]};
  endfunction
  // One request, held until taken, then its answer
  task automatic op(input logic w, k, input logic [1:0] ls, input logic [17:0] a,
    input logic [15:0] d);
    int n;
    int m;
    m = (ls[1] || ls == 0 ? 'hFF00 : 0) | (ls[0] || ls == 0 ? 'hFF : 0);
    req = {w, k, ls, a, d};
    req_valid = 1;
    n = 0;
    while (req_ready_reg !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req_valid = 0;
    n = 0;
    while ((w ? wdone_reg : rdata_valid_reg) !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(n < 20), 16'h0001);
    if (w) begin
      ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
    end else begin
      check(rdata_reg, 16'(ref_mem[a] & m));
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk_sys);
    nrst = 1;
    @(negedge clk_sys);
    for (int i = 0; i < 4; i++) op(1, i[0], 2'b11, addr_of(i[1:0]), 16'(i * 4661));
    $display("test corners done");
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      op(seed[9], seed[8], seed[7:6], addr_of(seed[5:4]), seed[31:16]);
    end
    $display("test random done");
    summarize();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
